//--- trc_consts.svh
`ifndef TRC_CONSTS_SVH
`define TRC_CONSTS_SVH
// register indexes; the byte address is four times the index
`define TRC_IDX_T1_RLD_HI 6'h15
`define TRC_IDX_T1_RLD_LO 6'h16
`define TRC_IDX_T1_CNT_HI 6'h17
`define TRC_IDX_T1_CNT_LO 6'h18
`define TRC_IDX_T2_CTRL 6'h19
`define TRC_IDX_T2_RLD_HI 6'h1A
`define TRC_IDX_T2_RLD_LO 6'h1B
`define TRC_IDX_T2_CNT_HI 6'h1C
`define TRC_IDX_T2_CNT_LO 6'h1D
`define TRC_IDX_IRQ_STAT 6'h30
`define TRC_IDX_IRQ_MASK 6'h31
`define TRC_IDX_T2_CMD 6'h32
// timer2 control fields
`define TRC_CTRL_HALT_BIT 7
`define TRC_CTRL_START_HI 5
`define TRC_CTRL_START_LO 4
`define TRC_CTRL_RELOAD_BIT 3
`define TRC_CTRL_SRC_HI 1
`define TRC_CTRL_SRC_LO 0
`define TRC_CTRL_WMASK 8'hBB
// status, mask and command bits
`define TRC_IRQ_T2_BIT 0
`define TRC_IRQ_T1_BIT 1
`define TRC_CMD_START_BIT 0
`define TRC_CMD_STOP_BIT 1
// reset values
`define TRC_RST_BYTE 8'h00
`define TRC_RST_IRQ 2'h0
// tick rates in kHz
`define TRC_MCLK_KHZ 50000
`define TRC_CARRIER_KHZ 13560
`define TRC_SLOW_KHZ 212
// bus answers
`define TRC_RESP_OKAY 2'h0
`define TRC_RESP_SLVERR 2'h2
`endif

//--- trc_pkg.sv
package trc_pkg;
  typedef enum logic [1:0] {
    TRC_START_NONE = 2'h0,
    TRC_START_TX_END = 2'h1,
    TRC_START_LFO = 2'h2,
    TRC_START_LFO_UF = 2'h3
  } trc_start_t;
  typedef enum logic [1:0] {
    TRC_SRC_CARRIER = 2'h0,
    TRC_SRC_SLOW = 2'h1,
    TRC_SRC_T0_UF = 2'h2,
    TRC_SRC_T1_UF = 2'h3
  } trc_src_t;
  typedef enum logic [2:0] {
    TRC_LFO_WAIT = 3'b001,
    TRC_LFO_COUNT = 3'b010,
    TRC_LFO_DONE = 3'b100
  } trc_lfo_st_t;
endpackage

//--- trc_tick_gen.sv
`timescale 1ns/10ps
// fractional divider: mean tick rate is STEP/MODULUS of mclk_i,
// so 13.56 MHz shows jitter of one cycle but no long-term drift
module trc_tick_gen #(
  parameter int unsigned STEP = 1,
  parameter int unsigned MODULUS = 2
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // one-cycle enable
  output logic tick_o
);
  localparam int W = $clog2(MODULUS) + 1;
  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic [W-1:0] sum;
  logic next_tick;

  always_comb begin
    sum = acc + W'(STEP);
    next_acc = sum;
    next_tick = 1'b0;
    if (sum >= W'(MODULUS)) begin
      next_acc = sum - W'(MODULUS);
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      acc <= '0;
      tick_o <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_o <= next_tick;
    end
  end
endmodule

//--- trc_timer_core.sv
`timescale 1ns/10ps
module trc_timer_core #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic tick_i,
  input wire logic reload_on_zero_i,
  input wire logic uf_enable_i,
  input wire logic [WIDTH-1:0] reload_i,
  // state
  output logic [WIDTH-1:0] count_o,
  output logic running_o,
  output logic underflow_o
);
  logic [WIDTH-1:0] next_count;
  logic next_run;
  logic next_uf;

  always_comb begin
    next_count = count_o;
    next_run = running_o;
    next_uf = 1'b0;
    if (start_i) begin
      next_count = reload_i; // [RULE2] [RULE15]
      next_run = 1'b1;
    end else if (stop_i) begin
      next_run = 1'b0;
    end else if (running_o && tick_i) begin
      if (count_o == '0) begin
        // a tick at zero is the underflow
        next_uf = uf_enable_i;
        if (reload_on_zero_i && uf_enable_i) begin
          next_count = reload_i; // [RULE10]
        end else begin
          next_run = 1'b0; // [RULE11]
        end
      end else begin
        next_count = count_o - 1'b1; // [RULE16]
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count_o <= '0;
      running_o <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      count_o <= next_count;
      running_o <= next_run;
      underflow_o <= next_uf;
    end
  end
endmodule

//--- trc_timer2_reload_counter.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "trc_consts.svh"
// Operation
// RULE1: writing timer1 reload low leaves a running count alone.
// RULE2: each timer1 start loads its count from both reload bytes.
// RULE3: index 17h reads the upper byte of the timer1 count.
// RULE4: index 18h reads the lower byte of the timer1 count.
// RULE5: software reads no count register while receiving.
// RULE6: halt bit set halts timer2 after the first received nibble.
// RULE7: the halt bit is ignored in oscillator trimming modes.
// RULE8: start mode 00b never starts, 01b starts at end of send.
// RULE9: modes 10b and 11b start and stop on oscillator rises.
// RULE10: reload bit set reloads timer2 at zero and keeps counting; in start mode 10b the code stops timer2 at zero instead.
// RULE11: reload bit clear stops timer2 at zero until a new start.
// RULE12: each timer2 underflow sets its sticky flag.
// RULE13: tick source 00b is the carrier, 01b the 212 kHz tick.
// RULE14: tick source 10b is timer0, 11b timer1 underflow.
// RULE15: each timer2 start loads both reload bytes.
// RULE16: a running timer decrements once per selected tick.
module trc_timer2_reload_counter (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // axi4-lite write channels
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read channels
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // frontend events, asynchronous
  input wire logic tx_end_i,
  input wire logic rx_nibble_i,
  input wire logic lfo_i,
  // neighbour timers, same clock
  input wire logic timer0_underflow_i,
  input wire logic timer1_start_i,
  // outputs
  output logic timer1_underflow_o,
  output logic timer2_underflow_o,
  output logic irq_o
);
  // pin synchronisers: 0 send end, 1 first nibble, 2 oscillator
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;
  logic [2:0] pin_rise;
  logic tx_rise;
  logic rx_rise;
  logic lfo_rise;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_last <= 3'h0;
    end else begin
      pin_meta <= {lfo_i, rx_nibble_i, tx_end_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_last;
  assign tx_rise = pin_rise[0];
  assign rx_rise = pin_rise[1];
  assign lfo_rise = pin_rise[2];

  // bus slave state
  logic aw_full, next_aw_full;
  logic [5:0] aw_idx, next_aw_idx;
  logic w_full, next_w_full;
  logic [7:0] w_byte, next_w_byte;
  logic w_be, next_w_be;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [7:0] rbyte, next_rbyte;
  logic [1:0] rresp, next_rresp;
  logic wr_go;
  logic wr_en;
  logic wr_hit;
  logic rd_take;
  logic rd_hit;
  logic [7:0] rd_val;

  // register file
  logic [7:0] t1_rld_hi, next_t1_rld_hi;
  logic [7:0] t1_rld_lo, next_t1_rld_lo;
  logic [7:0] t2_ctrl, next_t2_ctrl;
  logic [7:0] t2_rld_hi, next_t2_rld_hi;
  logic [7:0] t2_rld_lo, next_t2_rld_lo;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic next_irq;
  logic [1:0] irq_clr;
  logic ctrl_wr;
  logic cmd_start;
  logic cmd_stop;

  // timers
  logic carrier_tick;
  logic slow_tick;
  logic [15:0] t1_count;
  logic [7:0] t1_cnt_hi;
  logic [7:0] t1_cnt_lo;
  logic t1_uf;
  logic [15:0] t2_count;
  logic [15:0] t2_word;
  logic t2_run;
  logic t2_uf;
  logic t2_tick;
  logic start2;
  logic stop2;
  logic uf_en2;
  logic lfo_mode;
  logic lfo_arm;
  logic lfo_end;
  trc_pkg::trc_start_t t2_mode;
  trc_pkg::trc_src_t t2_src;
  trc_pkg::trc_lfo_st_t lfo_st, next_lfo_st;

  assign s_awready_o = ~aw_full;
  assign s_wready_o = ~w_full;
  assign s_bvalid_o = bvalid;
  assign s_bresp_o = bresp;
  assign s_arready_o = ~rvalid;
  assign s_rvalid_o = rvalid;
  assign s_rresp_o = rresp;
  assign s_rdata_o = {24'h000000, rbyte};
  // write waits until address and data are both held
  assign wr_go = aw_full & w_full & ~bvalid;
  assign wr_en = wr_go & w_be & wr_hit;
  assign rd_take = s_arvalid_i & ~rvalid;
  assign t1_cnt_hi = t1_count[15:8];
  assign t1_cnt_lo = t1_count[7:0];
  assign t2_word = {t2_rld_hi, t2_rld_lo};

  always_comb begin
    wr_hit = 1'b1;
    case (aw_idx)
      `TRC_IDX_T1_RLD_HI, `TRC_IDX_T1_RLD_LO, `TRC_IDX_T2_CTRL,
      `TRC_IDX_T2_RLD_HI, `TRC_IDX_T2_RLD_LO, `TRC_IDX_IRQ_STAT,
      `TRC_IDX_IRQ_MASK, `TRC_IDX_T2_CMD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // count reads are not valid during reception [RULE5]
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (s_araddr_i[7:2])
      `TRC_IDX_T1_RLD_HI: rd_val = t1_rld_hi;
      `TRC_IDX_T1_RLD_LO: rd_val = t1_rld_lo;
      `TRC_IDX_T1_CNT_HI: rd_val = t1_cnt_hi; // [RULE3]
      `TRC_IDX_T1_CNT_LO: rd_val = t1_cnt_lo; // [RULE4]
      `TRC_IDX_T2_CTRL: rd_val = t2_ctrl;
      `TRC_IDX_T2_RLD_HI: rd_val = t2_rld_hi;
      `TRC_IDX_T2_RLD_LO: rd_val = t2_rld_lo;
      `TRC_IDX_T2_CNT_HI: rd_val = t2_count[15:8];
      `TRC_IDX_T2_CNT_LO: rd_val = t2_count[7:0];
      `TRC_IDX_IRQ_STAT: rd_val = {6'h00, irq_stat};
      `TRC_IDX_IRQ_MASK: rd_val = {6'h00, irq_mask};
      `TRC_IDX_T2_CMD: rd_val = 8'h00;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_full = aw_full;
    next_aw_idx = aw_idx;
    next_w_full = w_full;
    next_w_byte = w_byte;
    next_w_be = w_be;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rbyte = rbyte;
    next_rresp = rresp;
    if (s_awvalid_i && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_idx = s_awaddr_i[7:2];
    end
    if (s_wvalid_i && !w_full) begin
      next_w_full = 1'b1;
      next_w_byte = s_wdata_i[7:0];
      next_w_be = s_wstrb_i[0];
    end
    if (bvalid && s_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? `TRC_RESP_OKAY : `TRC_RESP_SLVERR;
    end
    if (rvalid && s_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rbyte = rd_val;
      next_rresp = rd_hit ? `TRC_RESP_OKAY : `TRC_RESP_SLVERR;
    end
  end

  always_comb begin
    next_t1_rld_hi = t1_rld_hi;
    next_t1_rld_lo = t1_rld_lo;
    next_t2_ctrl = t2_ctrl;
    next_t2_rld_hi = t2_rld_hi;
    next_t2_rld_lo = t2_rld_lo;
    next_irq_mask = irq_mask;
    irq_clr = 2'h0;
    ctrl_wr = 1'b0;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    if (wr_en) begin
      case (aw_idx)
        `TRC_IDX_T1_RLD_HI: next_t1_rld_hi = w_byte;
        // only the reload copy changes, not the count [RULE1]
        `TRC_IDX_T1_RLD_LO: next_t1_rld_lo = w_byte;
        `TRC_IDX_T2_CTRL: begin
          next_t2_ctrl = w_byte & `TRC_CTRL_WMASK;
          ctrl_wr = 1'b1;
        end
        `TRC_IDX_T2_RLD_HI: next_t2_rld_hi = w_byte; // [RULE15]
        `TRC_IDX_T2_RLD_LO: next_t2_rld_lo = w_byte; // [RULE15]
        `TRC_IDX_IRQ_STAT: irq_clr = w_byte[1:0];
        `TRC_IDX_IRQ_MASK: next_irq_mask = w_byte[1:0];
        `TRC_IDX_T2_CMD: begin
          cmd_start = w_byte[`TRC_CMD_START_BIT];
          cmd_stop = w_byte[`TRC_CMD_STOP_BIT];
        end
        default: ;
      endcase
    end
    // a new underflow wins over a clear in the same cycle
    next_irq_stat = irq_stat & ~irq_clr;
    next_irq_stat[`TRC_IRQ_T2_BIT] = next_irq_stat[`TRC_IRQ_T2_BIT] | t2_uf;
    next_irq_stat[`TRC_IRQ_T1_BIT] = next_irq_stat[`TRC_IRQ_T1_BIT] | t1_uf;
    next_irq = |(irq_stat & irq_mask);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      aw_idx <= 6'h00;
      w_full <= 1'b0;
      w_byte <= `TRC_RST_BYTE;
      w_be <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TRC_RESP_OKAY;
      rvalid <= 1'b0;
      rbyte <= `TRC_RST_BYTE;
      rresp <= `TRC_RESP_OKAY;
      t1_rld_hi <= `TRC_RST_BYTE;
      t1_rld_lo <= `TRC_RST_BYTE;
      t2_ctrl <= `TRC_RST_BYTE;
      t2_rld_hi <= `TRC_RST_BYTE;
      t2_rld_lo <= `TRC_RST_BYTE;
      irq_stat <= `TRC_RST_IRQ;
      irq_mask <= `TRC_RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      aw_idx <= next_aw_idx;
      w_full <= next_w_full;
      w_byte <= next_w_byte;
      w_be <= next_w_be;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rbyte <= next_rbyte;
      rresp <= next_rresp;
      t1_rld_hi <= next_t1_rld_hi;
      t1_rld_lo <= next_t1_rld_lo;
      t2_ctrl <= next_t2_ctrl;
      t2_rld_hi <= next_t2_rld_hi;
      t2_rld_lo <= next_t2_rld_lo;
      irq_stat <= next_irq_stat; // [RULE12]
      irq_mask <= next_irq_mask;
      irq_o <= next_irq;
    end
  end

  // timer2 control decode
  assign t2_mode = trc_pkg::trc_start_t'(
    t2_ctrl[`TRC_CTRL_START_HI:`TRC_CTRL_START_LO]);
  assign t2_src = trc_pkg::trc_src_t'(
    t2_ctrl[`TRC_CTRL_SRC_HI:`TRC_CTRL_SRC_LO]);
  assign lfo_mode = (t2_mode == trc_pkg::TRC_START_LFO) ||
    (t2_mode == trc_pkg::TRC_START_LFO_UF);
  assign uf_en2 = t2_mode != trc_pkg::TRC_START_LFO; // [RULE9]
  assign lfo_arm = lfo_mode && !ctrl_wr && lfo_rise &&
    lfo_st == trc_pkg::TRC_LFO_WAIT;
  assign lfo_end = lfo_mode && !ctrl_wr && lfo_rise &&
    lfo_st == trc_pkg::TRC_LFO_COUNT;
  assign start2 = cmd_start || lfo_arm || // [RULE9]
    (t2_mode == trc_pkg::TRC_START_TX_END && tx_rise); // [RULE8]
  // the nibble halt is masked in trimming modes [RULE6] [RULE7]
  assign stop2 = cmd_stop || lfo_end ||
    (!lfo_mode && t2_ctrl[`TRC_CTRL_HALT_BIT] && rx_rise);

  always_comb begin
    t2_tick = carrier_tick;
    case (t2_src)
      trc_pkg::TRC_SRC_CARRIER: t2_tick = carrier_tick; // [RULE13]
      trc_pkg::TRC_SRC_SLOW: t2_tick = slow_tick; // [RULE13]
      trc_pkg::TRC_SRC_T0_UF: t2_tick = timer0_underflow_i; // [RULE14]
      trc_pkg::TRC_SRC_T1_UF: t2_tick = t1_uf; // [RULE14]
      default: t2_tick = 1'b0;
    endcase
  end

  // trimming window: first rise opens, second rise closes
  always_comb begin
    next_lfo_st = lfo_st;
    if (ctrl_wr || cmd_start || !lfo_mode) begin
      next_lfo_st = trc_pkg::TRC_LFO_WAIT;
    end else begin
      unique case (lfo_st)
        trc_pkg::TRC_LFO_WAIT:
          if (lfo_rise) next_lfo_st = trc_pkg::TRC_LFO_COUNT;
        trc_pkg::TRC_LFO_COUNT:
          if (lfo_rise) next_lfo_st = trc_pkg::TRC_LFO_DONE;
        trc_pkg::TRC_LFO_DONE: next_lfo_st = trc_pkg::TRC_LFO_DONE;
        default: next_lfo_st = trc_pkg::TRC_LFO_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lfo_st <= trc_pkg::TRC_LFO_WAIT;
    end else begin
      lfo_st <= next_lfo_st;
    end
  end

  trc_tick_gen #(
    .STEP(`TRC_CARRIER_KHZ),
    .MODULUS(`TRC_MCLK_KHZ)
  ) u_carrier (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_o(carrier_tick)
  );

  trc_tick_gen #(
    .STEP(`TRC_SLOW_KHZ),
    .MODULUS(`TRC_MCLK_KHZ)
  ) u_slow (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_o(slow_tick)
  );

  trc_timer_core #(
    .WIDTH(16)
  ) u_timer1 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(timer1_start_i),
    .stop_i(1'b0),
    .tick_i(carrier_tick),
    .reload_on_zero_i(1'b1),
    .uf_enable_i(1'b1),
    .reload_i({t1_rld_hi, t1_rld_lo}), // [RULE2]
    .count_o(t1_count),
    .running_o(),
    .underflow_o(t1_uf)
  );

  trc_timer_core #(
    .WIDTH(16)
  ) u_timer2 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(start2),
    .stop_i(stop2),
    .tick_i(t2_tick),
    .reload_on_zero_i(t2_ctrl[`TRC_CTRL_RELOAD_BIT]), // [RULE10]
    .uf_enable_i(uf_en2),
    .reload_i(t2_word), // [RULE15]
    .count_o(t2_count),
    .running_o(t2_run),
    .underflow_o(t2_uf)
  );

  assign timer1_underflow_o = t1_uf;
  assign timer2_underflow_o = t2_uf;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_t1_hi_read: assert property ( // [RULE3]
    rd_take && s_araddr_i[7:2] == `TRC_IDX_T1_CNT_HI |=>
    s_rvalid_o && s_rdata_o[7:0] == $past(t1_cnt_hi))
    else $error("timer1 high count read wrong");
  chk_t1_lo_read: assert property ( // [RULE4]
    rd_take && s_araddr_i[7:2] == `TRC_IDX_T1_CNT_LO |=>
    s_rvalid_o && s_rdata_o[7:0] == $past(t1_cnt_lo))
    else $error("timer1 low count read wrong");
  chk_t1_load: assert property ( // [RULE2]
    timer1_start_i |=> t1_count == {$past(t1_rld_hi), $past(t1_rld_lo)})
    else $error("timer1 start did not load reload word");
  chk_t1_lo_hold: assert property ( // [RULE1]
    !timer1_start_i && !carrier_tick |=> $stable(t1_count))
    else $error("timer1 count moved without tick or start");
  chk_rx_halt: assert property ( // [RULE6]
    t2_run && rx_rise && t2_ctrl[`TRC_CTRL_HALT_BIT] && !lfo_mode
    && !start2 |=> !t2_run)
    else $error("timer2 not halted after first nibble");
  chk_lfo_no_halt: assert property ( // [RULE7]
    lfo_mode && t2_run && !stop2 && !(t2_tick && t2_count == 16'h0000)
    |=> t2_run)
    else $error("timer2 stopped by receive in trimming mode");
  chk_tx_start: assert property ( // [RULE8]
    t2_mode == trc_pkg::TRC_START_TX_END && tx_rise ##1 !stop2 |=>
    t2_run && (t2_count == $past(t2_word, 2) ||
    t2_count == $past(t2_word, 2) - 16'h0001))
    else $error("timer2 not started at end of send");
  chk_no_autostart: assert property ( // [RULE8]
    t2_mode == trc_pkg::TRC_START_NONE && !cmd_start && !t2_run
    |=> !t2_run)
    else $error("timer2 started on its own in mode 00b");
  chk_lfo_edges: assert property ( // [RULE9]
    lfo_arm && !stop2 && !cmd_start |=>
    t2_run ##0 lfo_st == trc_pkg::TRC_LFO_COUNT)
    else $error("oscillator rise did not start timer2");
  chk_reload_zero: assert property ( // [RULE10]
    t2_run && t2_tick && t2_count == 16'h0000 && uf_en2 && !start2
    && !stop2 && t2_ctrl[`TRC_CTRL_RELOAD_BIT] |=>
    t2_run && t2_uf && t2_count == $past(t2_word))
    else $error("timer2 did not reload at zero");
  chk_stop_zero: assert property ( // [RULE11]
    t2_run && t2_tick && t2_count == 16'h0000 && !start2 && !stop2
    && !t2_ctrl[`TRC_CTRL_RELOAD_BIT] |=>
    !t2_run && t2_count == 16'h0000)
    else $error("timer2 did not stop at zero");
  chk_uf_flag: assert property ( // [RULE12]
    t2_uf |=> irq_stat[`TRC_IRQ_T2_BIT])
    else $error("timer2 underflow flag not set");
  chk_carrier_tick: assert property ( // [RULE13] [RULE16]
    t2_src == trc_pkg::TRC_SRC_CARRIER && t2_run && !start2 && !stop2
    && t2_count != 16'h0000 |=>
    t2_count == $past(t2_count) - 16'(($past(carrier_tick))))
    else $error("timer2 not counting carrier ticks");
  chk_cascade_tick: assert property ( // [RULE14] [RULE16]
    t2_src == trc_pkg::TRC_SRC_T1_UF && t2_run && !start2 && !stop2
    && t2_count != 16'h0000 |=>
    t2_count == $past(t2_count) - 16'(($past(t1_uf))))
    else $error("timer2 not counting timer1 underflows");
  chk_t2_load: assert property ( // [RULE15]
    cmd_start |=> t2_run && t2_count == $past(t2_word))
    else $error("timer2 start did not load reload word");
endmodule

//--- tb_trc_timer2_reload_counter.sv
`timescale 1ns/10ps
module tb_trc_timer2_reload_counter;
  typedef struct {
    logic [5:0] a;
    logic [7:0] w;
    logic [7:0] e;
    logic [1:0] rs;
  } trc_row_t;
  logic mclk_i, rst_i, s_awvalid_i, s_wvalid_i, s_bready_i;
  logic s_arvalid_i, s_rready_i, tx_end_i, rx_nibble_i, lfo_i;
  logic timer0_underflow_i, timer1_start_i;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic timer1_underflow_o, timer2_underflow_o, irq_o;
  logic [7:0] s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o, d;
  logic [3:0] s_wstrb_i;
  logic [1:0] s_bresp_o, s_rresp_o, r;
  logic [15:0] c0, c1;
  int fails, comparisons, cyc, n, m;
  logic [7:0] lm[2] = '{8'hA0, 8'hB0};
  // unused control bits read back 0; index 3Fh is unmapped
  trc_row_t rows[6] = '{
    '{6'h19, 8'hFF, 8'hBB, 2'h0},
    '{6'h1A, 8'hA5, 8'hA5, 2'h0},
    '{6'h1B, 8'h5A, 8'h5A, 2'h0},
    '{6'h15, 8'h12, 8'h12, 2'h0},
    '{6'h16, 8'h34, 8'h34, 2'h0},
    '{6'h3F, 8'hFF, 8'h00, 2'h2}
  };

  trc_timer2_reload_counter dut (
    .mclk_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
    .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o,
    .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
    .tx_end_i, .rx_nibble_i, .lfo_i, .timer0_underflow_i,
    .timer1_start_i, .timer1_underflow_o, .timer2_underflow_o, .irq_o
  );

  initial begin
    mclk_i = 1'h0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  // handshakes are sampled at the falling edge, where the values that
  // the next rising edge takes are settled, and released after it
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic aw, wd, b;
    b = 1'h0;
    s_awaddr_i <= {a, 2'h0};
    s_wdata_i <= {24'h0, v};
    s_awvalid_i <= 1'h1;
    s_wvalid_i <= 1'h1;
    s_bready_i <= 1'h1;
    while (!b) begin
      @(negedge mclk_i);
      aw = s_awvalid_i & s_awready_o;
      wd = s_wvalid_i & s_wready_o;
      b = s_bvalid_o;
      r = s_bresp_o;
      @(posedge mclk_i);
      if (aw) s_awvalid_i <= 1'h0;
      if (wd) s_wvalid_i <= 1'h0;
    end
    s_bready_i <= 1'h0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [5:0] a);
    logic ar, b;
    b = 1'h0;
    s_araddr_i <= {a, 2'h0};
    s_arvalid_i <= 1'h1;
    s_rready_i <= 1'h1;
    while (!b) begin
      @(negedge mclk_i);
      ar = s_arvalid_i & s_arready_o;
      b = s_rvalid_o;
      d = s_rdata_o;
      r = s_rresp_o;
      @(posedge mclk_i);
      if (ar) s_arvalid_i <= 1'h0;
    end
    s_rready_i <= 1'h0;
    @(posedge mclk_i);
  endtask

  task automatic cnt(output logic [15:0] c);
    rd(6'h1C);
    c[15:8] = d[7:0];
    rd(6'h1D);
    c[7:0] = d[7:0];
  endtask

  // count reads are only taken with reception over
  task automatic spn;
    cnt(c0);
    repeat (20) @(posedge mclk_i);
    cnt(c1);
  endtask

  task automatic cu(input int k);
    n = 0;
    m = 0;
    repeat (k) begin
      @(negedge mclk_i);
      n += timer2_underflow_o;
      m += timer1_underflow_o;
    end
    @(posedge mclk_i);
  endtask

  // bits are lfo, rx nibble, end of send; held long enough to sync
  task automatic pin(input logic [2:0] v);
    {lfo_i, rx_nibble_i, tx_end_i} <= v;
    repeat (8) @(posedge mclk_i);
    {lfo_i, rx_nibble_i, tx_end_i} <= 3'h0;
    repeat (6) @(posedge mclk_i);
  endtask

  task automatic t1go;
    timer1_start_i <= 1'h1;
    @(posedge mclk_i);
    timer1_start_i <= 1'h0;
  endtask

  initial begin
    rst_i = 1'h1;
    {s_awvalid_i, s_wvalid_i, s_bready_i} = 3'h0;
    {s_arvalid_i, s_rready_i} = 2'h0;
    {tx_end_i, rx_nibble_i, lfo_i} = 3'h0;
    {timer0_underflow_i, timer1_start_i} = 2'h0;
    s_awaddr_i = 8'h00;
    s_araddr_i = 8'h00;
    s_wdata_i = 32'h0;
    s_wstrb_i = 4'hF;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'h0;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk("reset value", 32'h0, d);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("write response", rows[i].rs, r);
      rd(rows[i].a);
      chk("read data", rows[i].e, d);
      chk("read response", rows[i].rs, r);
    end
    wr(6'h17, 8'hFF);
    rd(6'h17);
    chk("read-only count", 32'h0, d);
    wr(6'h19, 8'h00);
    $display("test registers done");
    t1go;
    rd(6'h17);
    chk("t1 count high", 32'h12, d);
    rd(6'h18);
    chk("t1 count low", 1, d > 32'h20 && d < 32'h35);
    wr(6'h16, 8'h80);
    rd(6'h18);
    chk("t1 low kept", 1, d < 32'h34);
    t1go;
    rd(6'h18);
    chk("t1 low reloaded", 1, d > 32'h60);
    $display("test timer1 done");
    wr(6'h31, 8'h01);
    wr(6'h1A, 8'h00);
    wr(6'h1B, 8'h05);
    wr(6'h32, 8'h01);
    cu(200);
    chk("t2 single underflow", 1, n);
    cnt(c0);
    chk("t2 held at zero", 0, c0);
    rd(6'h30);
    chk("status", 1, d);
    chk("irq", 1, irq_o);
    wr(6'h31, 8'h00);
    chk("irq masked", 0, irq_o);
    rd(6'h30);
    chk("status kept", 1, d);
    wr(6'h31, 8'h01);
    wr(6'h30, 8'h01);
    rd(6'h30);
    chk("status cleared", 0, d);
    chk("irq cleared", 0, irq_o);
    $display("test underflow done");
    wr(6'h19, 8'h08);
    wr(6'h32, 8'h01);
    cu(200);
    chk("carrier reloads", 1, n >= 8 && n <= 10);
    wr(6'h19, 8'h09);
    wr(6'h32, 8'h01);
    cu(2000);
    chk("slow tick underflows", 1, n);
    wr(6'h32, 8'h02);
    wr(6'h1A, 8'h01);
    wr(6'h1B, 8'h00);
    wr(6'h19, 8'h02);
    wr(6'h32, 8'h01);
    repeat (5) begin
      timer0_underflow_i <= 1'h1;
      @(posedge mclk_i);
      timer0_underflow_i <= 1'h0;
      @(posedge mclk_i);
    end
    cnt(c0);
    chk("timer0 cascade", 32'h00FB, c0);
    wr(6'h15, 8'h00);
    wr(6'h16, 8'h03);
    t1go;
    wr(6'h19, 8'h03);
    cnt(c0);
    cu(300);
    cnt(c1);
    chk("t1 underflows", 1, m > 10);
    chk("timer1 cascade", 1, c0 - c1 >= m - 1 && c0 - c1 <= m + 2);
    $display("test sources done");
    wr(6'h1A, 8'hFF);
    wr(6'h1B, 8'hFF);
    wr(6'h19, 8'h80);
    wr(6'h32, 8'h01);
    pin(3'h2);
    spn;
    chk("halted on nibble", c0, c1);
    wr(6'h19, 8'h00);
    wr(6'h32, 8'h01);
    pin(3'h2);
    spn;
    chk("no halt", 1, c1 < c0);
    foreach (lm[i]) begin
      wr(6'h32, 8'h02);
      wr(6'h19, lm[i]);
      pin(3'h4);
      pin(3'h2);
      spn;
      chk("trim running", 1, c1 < c0);
      pin(3'h4);
      spn;
      chk("trim stopped", c0, c1);
    end
    // 10b must stop at zero silently, 11b must flag the underflow
    wr(6'h1A, 8'h00);
    wr(6'h1B, 8'h08);
    foreach (lm[i]) begin
      wr(6'h19, lm[i] & 8'h30);
      pin(3'h4);
      cu(100);
      chk("trim underflow", i, n);
    end
    $display("test halt and trim done");
    wr(6'h32, 8'h02);
    wr(6'h1A, 8'h00);
    wr(6'h1B, 8'h40);
    wr(6'h19, 8'h00);
    cnt(c0);
    pin(3'h1);
    cnt(c1);
    chk("no autostart", c0, c1);
    wr(6'h19, 8'h10);
    pin(3'h1);
    cnt(c1);
    chk("autostart", 1, c1 <= 16'h0040 && c1 > 16'h0020);
    $display("test autostart done");
    print_verdict;
  end
endmodule
